//--- rtl/sstx_pkg.sv
// Purpose: Shared types and constants for the skip/swap/table/xor execution unit
// Assumes: 8-bit data path, 15-bit program ROM words, 11-bit program address
// Notes:   Operation codes are the decoder's own, not the instruction encoding
`default_nettype none
package sstx_pkg;
    localparam int DATA_W   = 8;
    localparam int ROM_W    = 15;
    localparam int PC_W     = 11;
    localparam int NIB_W    = 4;
    localparam int LOW_BYTE = 0;
    localparam int HIGH_LSB = 8;
    localparam int HIGH_W   = ROM_W - HIGH_LSB;
    localparam int BIT_SEL_W = 3;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0]        PAGE_ALL_ONES = 8'hff;

    typedef enum logic [3:0] {
        SSTX_OP_NONE,
        SSTX_OP_NIBBLE_SWAP_TO_ACC,
        SSTX_OP_SKIP_ZERO,
        SSTX_OP_MOVE_SKIP_ZERO,
        SSTX_OP_SKIP_BIT_ZERO,
        SSTX_OP_TABLE_CUR,
        SSTX_OP_TABLE_LAST,
        SSTX_OP_XOR_ACC,
        SSTX_OP_XOR_MEM,
        SSTX_OP_XOR_IMM
    } sstx_op_type;

    typedef struct packed {
        logic                 valid;
        sstx_op_type          op;
        logic [DATA_W-1:0]    mem_data;
        logic [DATA_W-1:0]    literal;
        logic [BIT_SEL_W-1:0] bit_sel;
        logic [PC_W-1:0]      pc;
    } sstx_issue_type;

    typedef struct packed {
        logic              acc_we;
        logic [DATA_W-1:0] acc_data;
        logic              mem_we;
        logic [DATA_W-1:0] mem_data;
        logic              zero_we;
        logic              zero_val;
        logic              tbl_high_we;
        logic [HIGH_W-1:0] tbl_high;
    } sstx_wb_type;
endpackage
`default_nettype wire

//--- rtl/sstx_exec.sv
// Purpose: Execution of nibble swap, zero skips, table reads and exclusive-OR
// Assumes: Operand byte is already read; ROM answers its address in the same cycle
// Notes:   Table read low byte goes to memory, high byte to table_high_latch
//
// Summary of operation
// - Swap nibbles into accumulator; memory untouched
// - Skip next instruction when byte is zero
// - Taken skip flushes prefetch, inserts dummy cycle
// - Skip takes two cycles, else one
// - Move byte to accumulator, skip if zero
// - Skip when selected bit is zero
// - Current-page table read at table pointer
// - Low byte to memory, high to latch
// - Last-page table read uses final page
// - XOR into accumulator, only zero flag
// - XOR into memory, updates zero flag
// - XOR literal into accumulator, zero flag
`default_nettype none
module sstx_exec #(
    parameter int PC_W = sstx_pkg::PC_W
) (
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    input  wire sstx_pkg::sstx_issue_type      issue,
    input  wire logic [sstx_pkg::DATA_W-1:0]   acc,
    input  wire logic [sstx_pkg::DATA_W-1:0]   table_pointer,
    input  wire logic [sstx_pkg::ROM_W-1:0]    rom_data,
    output logic      [PC_W-1:0]               rom_addr,
    output sstx_pkg::sstx_wb_type              wb,
    output logic                               flush_prefetch,
    output logic                               stall,
    output logic [sstx_pkg::HIGH_W-1:0]        table_high_latch
);
    localparam int PAGE_W = PC_W - sstx_pkg::DATA_W;

    // Writeback group
    sstx_pkg::sstx_wb_type         wb_d, wb_q;

    // Skip group
    logic                          flush_d, flush_q;
    logic                          dummy_d, dummy_q;

    // Table group
    logic [PC_W-1:0]               addr_d, addr_q;
    logic [sstx_pkg::HIGH_W-1:0]   thl_d, thl_q;

    // Shared decode
    logic [sstx_pkg::DATA_W-1:0]   x_operand;
    logic [sstx_pkg::DATA_W-1:0]   x_res;
    logic [sstx_pkg::DATA_W-1:0]   bit_mask;
    logic [PC_W-1:0]               table_addr;
    logic                          sel_bit;
    logic                          byte_zero;
    logic                          xor_zero;
    logic                          take_skip;
    logic                          is_table;
    logic                          is_last;
    logic                          is_xor;
    logic                          issue_ok;

    // An issue arriving during the dummy cycle belongs to the flushed slot
    assign issue_ok = issue.valid && !dummy_q;

    // One-hot bit select; avoids a variable index that tools may widen
    genvar gi;
    generate
        for (gi = 0; gi < sstx_pkg::DATA_W; gi++) begin : g_bit_mask
            assign bit_mask[gi] = (issue.bit_sel == sstx_pkg::BIT_SEL_W'(gi));
        end
    endgenerate

    assign sel_bit   = |(bit_mask & issue.mem_data);
    assign byte_zero = (issue.mem_data == sstx_pkg::ZERO_BYTE);
    assign x_res     = acc ^ x_operand;
    assign xor_zero  = (x_res == sstx_pkg::ZERO_BYTE);

    // Operation classes and skip decision
    always_comb begin
        take_skip = 1'b0;
        is_table  = 1'b0;
        is_last   = 1'b0;
        is_xor    = 1'b0;
        x_operand = issue.mem_data;
        if (issue_ok) begin
            unique case (issue.op)
                sstx_pkg::SSTX_OP_NONE,
                sstx_pkg::SSTX_OP_NIBBLE_SWAP_TO_ACC: begin
                end
                sstx_pkg::SSTX_OP_SKIP_ZERO: begin
                    take_skip = byte_zero;
                end
                sstx_pkg::SSTX_OP_MOVE_SKIP_ZERO: begin
                    take_skip = byte_zero;
                end
                sstx_pkg::SSTX_OP_SKIP_BIT_ZERO: begin
                    take_skip = !sel_bit;
                end
                sstx_pkg::SSTX_OP_TABLE_CUR: begin
                    is_table = 1'b1;
                end
                sstx_pkg::SSTX_OP_TABLE_LAST: begin
                    is_table = 1'b1;
                    is_last  = 1'b1;
                end
                sstx_pkg::SSTX_OP_XOR_ACC,
                sstx_pkg::SSTX_OP_XOR_MEM: begin
                    is_xor = 1'b1;
                end
                sstx_pkg::SSTX_OP_XOR_IMM: begin
                    is_xor    = 1'b1;
                    x_operand = issue.literal;
                end
                default: begin
                end
            endcase
        end
    end

    // Writeback next values
    always_comb begin
        // Every flag strobe starts low; only an exclusive-OR raises one
        wb_d = '0;
        if (issue_ok) begin
            unique case (issue.op)
                sstx_pkg::SSTX_OP_NIBBLE_SWAP_TO_ACC: begin
                    wb_d.acc_we   = 1'b1;
                    wb_d.acc_data = {issue.mem_data[sstx_pkg::NIB_W-1:0],
                                     issue.mem_data[sstx_pkg::DATA_W-1:sstx_pkg::NIB_W]};
                end
                sstx_pkg::SSTX_OP_MOVE_SKIP_ZERO: begin
                    wb_d.acc_we   = 1'b1;
                    wb_d.acc_data = issue.mem_data;
                end
                sstx_pkg::SSTX_OP_XOR_ACC: begin
                    wb_d.acc_we   = 1'b1;
                    wb_d.acc_data = x_res;
                end
                sstx_pkg::SSTX_OP_XOR_MEM: begin
                    wb_d.mem_we   = 1'b1;
                    wb_d.mem_data = x_res;
                end
                sstx_pkg::SSTX_OP_XOR_IMM: begin
                    wb_d.acc_we   = 1'b1;
                    wb_d.acc_data = x_res;
                end
                sstx_pkg::SSTX_OP_NONE,
                sstx_pkg::SSTX_OP_SKIP_ZERO,
                sstx_pkg::SSTX_OP_SKIP_BIT_ZERO,
                sstx_pkg::SSTX_OP_TABLE_CUR,
                sstx_pkg::SSTX_OP_TABLE_LAST: begin
                end
                default: begin
                end
            endcase
        end
        wb_d.zero_we  = is_xor;
        wb_d.zero_val = is_xor && xor_zero;
        // ROM answers in the issue cycle, so both halves are taken here
        if (is_table) begin
            wb_d.mem_we      = 1'b1;
            wb_d.mem_data    = rom_data[sstx_pkg::LOW_BYTE +: sstx_pkg::DATA_W];
            wb_d.tbl_high_we = 1'b1;
            wb_d.tbl_high    = rom_data[sstx_pkg::HIGH_LSB +: sstx_pkg::HIGH_W];
        end
    end

    // Skip next values: flush pulse and one dummy slot, both in the same cycle
    always_comb begin
        flush_d = take_skip;
        dummy_d = take_skip;
    end

    // Table next values; address and latch hold between table reads
    always_comb begin
        table_addr = {issue.pc[PC_W-1:sstx_pkg::DATA_W], table_pointer};
        if (is_last) begin
            table_addr = {{PAGE_W{1'b1}}, table_pointer};
        end
        addr_d = addr_q;
        thl_d  = thl_q;
        if (is_table) begin
            addr_d = table_addr;
            thl_d  = rom_data[sstx_pkg::HIGH_LSB +: sstx_pkg::HIGH_W];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_q <= '0;
        end else begin
            wb_q <= wb_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flush_q <= 1'b0;
            dummy_q <= 1'b0;
        end else begin
            flush_q <= flush_d;
            dummy_q <= dummy_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= '0;
            thl_q  <= '0;
        end else begin
            addr_q <= addr_d;
            thl_q  <= thl_d;
        end
    end

    // Address is only a record of the last table access; the fetch unit
    // must already present the word in the issue cycle
    assign rom_addr         = addr_q;
    assign wb               = wb_q;
    assign flush_prefetch   = flush_q;
    assign stall            = dummy_q;
    assign table_high_latch = thl_q;
endmodule
`default_nettype wire

//--- tb/sstx_chk.sv
// Purpose: Port checks for the execution unit
// Assumes: Results land one cycle after a taken issue
// Notes:   Bound into every sstx_exec
`default_nettype none
module sstx_chk #(parameter int PC_W = sstx_pkg::PC_W) (
    input wire logic                     core_clk,
    input wire logic                     rst_n,
    input wire sstx_pkg::sstx_issue_type issue,
    input wire logic [7:0]               acc,
    input wire logic [7:0]               table_pointer,
    input wire logic [14:0]              rom_data,
    input wire logic [PC_W-1:0]          rom_addr,
    input wire sstx_pkg::sstx_wb_type    wb,
    input wire logic                     flush_prefetch,
    input wire logic                     stall,
    input wire logic [6:0]               table_high_latch
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Taken operations one-hot by enum value; issues in a dummy cycle never count
    wire logic [9:0] t = {10{issue.valid && !stall}} & (10'h001 << issue.op);
    wire logic [7:0] m = issue.mem_data;
    wire logic [7:0] x = acc ^ (t[9] ? issue.literal : m);
    AST_SWAP: assert property (t[1] |=> wb.acc_we && !wb.mem_we && !wb.zero_we
        && wb.acc_data == {$past(m[3:0]), $past(m[7:4])}) else $error("swap result wrong");
    AST_SKIP: assert property (t[2] |=> flush_prefetch == ($past(m) == 8'h00) && !wb.zero_we)
        else $error("zero skip wrong");
    AST_DUMMY: assert property (flush_prefetch |-> stall ##1 !stall) else $error("dummy cycle wrong");
    AST_MOVE: assert property (t[3] |=> wb.acc_we && wb.acc_data == $past(m) && flush_prefetch == !$past(|m))
        else $error("move skip wrong");
    AST_BIT: assert property (t[4] |=> flush_prefetch == !$past(m[issue.bit_sel])) else $error("bit skip wrong");
    AST_TBL: assert property (t[5] | t[6] |=> wb.mem_we && wb.tbl_high_we && !wb.zero_we
        && {table_high_latch, wb.mem_data} == $past(rom_data)) else $error("table read wrong");
    AST_LAST: assert property (t[6] |=> rom_addr == {{(PC_W-8){1'b1}}, $past(table_pointer)})
        else $error("last page wrong");
    AST_CUR: assert property (t[5] |=> rom_addr == {$past(issue.pc[PC_W-1:8]), $past(table_pointer)})
        else $error("current page wrong");
    AST_XOR: assert property (t[7] | t[8] | t[9] |=> wb.zero_we && wb.zero_val == ($past(x) == 8'h00)
        && wb.mem_we == $past(t[8]) && wb.acc_we == !$past(t[8]) && (wb.mem_we ? wb.mem_data : wb.acc_data) == $past(x))
        else $error("xor result wrong");
    cover property (t[2] && m == 8'h00);
    cover property (issue.valid && stall);
    cover property (t[6]);
endmodule
bind sstx_exec sstx_chk #(.PC_W(PC_W)) u_chk (.core_clk, .rst_n, .issue, .acc, .table_pointer, .rom_data,
    .rom_addr, .wb, .flush_prefetch, .stall, .table_high_latch);
`default_nettype wire

//--- tb/tb.sv
// Purpose: Directed bench for the execution unit
// Assumes: Bench plays decoder and ROM
// Notes:   Inputs move on the falling edge
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                     core_clk = 1'h0;
    logic                     rst_n = 1'h0;
    sstx_pkg::sstx_issue_type issue = '0;
    logic [14:0]              rom_data = 15'h0000;
    logic [10:0]              rom_addr;
    sstx_pkg::sstx_wb_type    wb;
    logic                     flush_prefetch, stall;
    logic [6:0]               table_high_latch;
    logic [7:0]               acc = 8'h5a;
    logic [7:0]               table_pointer = 8'h96;
    int                       error_cnt = 0, comparisons = 0;
    sstx_exec DUT (.core_clk, .rst_n, .issue, .acc, .table_pointer, .rom_data, .rom_addr, .wb,
        .flush_prefetch, .stall, .table_high_latch);
    initial forever #10 core_clk = ~core_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Op is the enum value; result is visible at the next falling edge
    task automatic go(input logic [3:0] op, input logic [7:0] m, input logic [7:0] l);
        issue = '{1'h1, sstx_pkg::sstx_op_type'(op), m, l, 3'h5, 11'h6a5};
        @(negedge core_clk);
    endtask
    task automatic t_swap;
        go(4'h1, 8'h3c, 8'h00);
        chk({wb.acc_we, wb.mem_we, wb.zero_we, wb.acc_data}, {3'h4, 8'hc3});
    endtask
    // Even cases skip; an issue in the dummy cycle must vanish
    task automatic t_skip;
        logic [7:0] ms[6] = '{8'h00, 8'h01, 8'h00, 8'h80, 8'hdf, 8'h20};
        for (int i = 0; i < 6; i++) begin
            go(4'(2 + i / 2), ms[i], 8'h00);
            chk({flush_prefetch, stall, wb.zero_we}, {i % 2 == 0, i % 2 == 0, 1'h0});
            go(4'h9, 8'h00, 8'h11);
            chk({flush_prefetch, stall, wb.acc_we}, {2'h0, i % 2 == 1});
        end
    endtask
    task automatic t_table;
        for (int i = 0; i < 2; i++) begin
            rom_data = i ? 15'h2a81 : 15'h5a3c;
            go(4'(5 + i), 8'h00, 8'h00);
            chk({rom_addr, table_high_latch, wb.mem_data}, {i ? 3'h7 : 3'h6, table_pointer, rom_data});
            chk({wb.mem_we, wb.tbl_high_we, wb.zero_we, wb.tbl_high}, {3'h6, rom_data[14:8]});
        end
    endtask
    task automatic t_xor;
        logic [7:0] v[6] = '{8'h5a, 8'h0f, 8'ha5, 8'h5a, 8'h5a, 8'h01};
        logic [7:0] e;
        logic [7:0] d;
        for (int i = 0; i < 6; i++) begin
            e = acc ^ v[i];
            go(4'(7 + i / 2), i < 4 ? v[i] : ~v[i], i < 4 ? ~v[i] : v[i]);
            d = i / 2 == 1 ? wb.mem_data : wb.acc_data;
            chk({wb.acc_we, wb.mem_we, wb.zero_we, wb.zero_val, d},
                {i / 2 != 1, i / 2 == 1, 1'h1, e == 8'h00, e});
        end
    endtask
    task automatic tally_and_finish;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #(300 * 20);
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(negedge core_clk);
        rst_n = 1'h1;
        t_swap();
        t_skip();
        t_table();
        t_xor();
        tally_and_finish();
    end
endmodule
`default_nettype wire
